// file: rtl/pmw_defines.vh
// Purpose: Constants for the power mode and wakeup control block
// Assumes: Byte-wide power control register at the printed address
// Notes:   Included by pmw_top.v only
`ifndef PMW_DEFINES_VH
`define PMW_DEFINES_VH
`define PMW_ADDR_POWER_CONTROL_REG      8'h87
`define PMW_BIT_BAUD2      7
`define PMW_BIT_SER7       6
`define PMW_BIT_BOF        5
`define PMW_BIT_POF        4
`define PMW_BIT_GF1        3
`define PMW_BIT_GF0        2
`define PMW_BIT_PD         1
`define PMW_BIT_IDL        0
`define PMW_RST_POWERON    8'h30
`define PMW_RST_BROWNOUT   8'h20
`define PMW_RST_OTHER      8'h00
`define PMW_FLAG_KEEP_MASK 8'h30
`define PMW_XTAL_WAIT      11'h400
`define PMW_RC_WAIT        11'h100
`define PMW_WAIT_W         11
`define PMW_SYNC_W         9
`define PMW_SYNC_RST       9'h000
`define PMW_SRC_EXT0       0
`define PMW_SRC_EXT1       1
`define PMW_SRC_KBD        2
`define PMW_SRC_CMP1       3
`define PMW_SRC_CMP2       4
`define PMW_SRC_WDT        5
`define PMW_SRC_BO         6
`define PMW_SRC_RST        7
`define PMW_SRC_ADC        8
`endif

// file: rtl/pmw_top.v
// Purpose: Power control register, idle/power-down modes and wakeup logic
// Assumes: Event inputs are asynchronous to clock; every power-down wake source passes two flops, the idle wake any_irq does not
// Notes:   Oscillator gating shown by osc_run; restart counts CPU clocks
`timescale 1ns/1ps
`include "pmw_defines.vh"
module pmw_top
(
  // Clock and reset
  input  wire       clock,
  input  wire       reset,
  // Reset cause, sampled while reset is high
  input  wire       por_cause,
  input  wire       bor_cause,
  // Register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // Configuration
  input  wire       watchdog_enable_cfg,
  input  wire       brownout_disable,
  input  wire       brownout_irq_select,
  input  wire       adc_rc_clock_select,
  input  wire       ext_reset_enable,
  input  wire       crystal_mode,
  // Interrupt enables and feature set-up
  input  wire [1:0] ext_irq_en,
  input  wire       kbd_ready,
  input  wire       kbd_irq_en,
  input  wire [1:0] cmp_ready,
  input  wire [1:0] cmp_irq_en,
  input  wire       wdt_irq_en,
  input  wire       bo_irq_en,
  input  wire       adc_ready,
  input  wire       adc_irq_en,
  input  wire       irq_pri_ok,
  input  wire       any_irq,
  // Wake events (pins and RC-clocked units)
  input  wire [1:0] ext_irq_pin,
  input  wire       kbd_irq_pin,
  input  wire [1:0] cmp_event,
  input  wire       wdt_overflow,
  input  wire       brownout_event,
  input  wire       ext_reset_pin,
  input  wire       adc_done,
  // Serial bit 7 steering
  input  wire       serial_bit7_wr,
  input  wire       serial_bit7_wdata,
  input  wire       framing_error_flag,
  output reg        serial_mode_bit0,
  output wire       serial_bit7_read,
  // Mode outputs
  output wire       osc_run,
  output wire       cpu_hold,
  output wire       idle_mode,
  output wire       power_down_mode,
  output wire       analog_run,
  output reg        wake_reset,
  output wire       baud_double
);
  localparam ST_RUN  = 3'b001;
  localparam ST_PD   = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg  [7:0]               power_control_reg;
  reg  [7:0]               power_control_next;
  reg  [2:0]               state_reg;
  reg  [2:0]               state_next;
  reg  [`PMW_WAIT_W-1:0]   wait_reg;
  reg  [`PMW_WAIT_W-1:0]   wait_next;
  reg  [`PMW_SYNC_W-1:0]   sync1_reg;
  reg  [`PMW_SYNC_W-1:0]   sync2_reg;
  wire [`PMW_SYNC_W-1:0]   pin_raw;
  wire [1:0]               ext_wake;
  wire [1:0]               cmp_wake;
  wire                     kbd_wake;
  wire                     wdt_irq_wake;
  wire                     bo_irq_wake;
  wire                     adc_wake;
  wire                     wdt_rst_wake;
  wire                     bo_rst_wake;
  wire                     pin_rst_wake;
  wire                     bo_seen;
  wire                     power_control_reg_sel;
  wire                     pd_done;
  wire                     idle_active;
  genvar                   ch;
  wire                     power_control_reg_wr;
  wire                     irq_wake;
  wire                     rst_wake;
  wire                     idle_end;
  wire [`PMW_WAIT_W-1:0]   wait_len;

  // ************************************************
  // Pin synchronisers
  // ************************************************
  // One bit per wake source, each pin kept apart so its own enable applies
  assign pin_raw[`PMW_SRC_EXT0] = ext_irq_pin[0];
  assign pin_raw[`PMW_SRC_EXT1] = ext_irq_pin[1];
  assign pin_raw[`PMW_SRC_KBD]  = kbd_irq_pin;
  assign pin_raw[`PMW_SRC_CMP1] = cmp_event[0];
  assign pin_raw[`PMW_SRC_CMP2] = cmp_event[1];
  assign pin_raw[`PMW_SRC_WDT]  = wdt_overflow;
  assign pin_raw[`PMW_SRC_BO]   = brownout_event;
  assign pin_raw[`PMW_SRC_RST]  = ext_reset_pin;
  assign pin_raw[`PMW_SRC_ADC]  = adc_done;

  // Two flops per asynchronous wake source
  always @(posedge clock)
  begin
    if (reset)
    begin
      sync1_reg <= `PMW_SYNC_RST;
      sync2_reg <= `PMW_SYNC_RST;
    end
    else
    begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ************************************************
  // Wake qualification
  // ************************************************
  // External interrupts, each gated by its own enable
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_ext
      assign ext_wake[ch] = sync2_reg[`PMW_SRC_EXT0 + ch] & ext_irq_en[ch];
    end
  endgenerate

  // Comparators, each needing set-up and its own enable
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_cmp
      assign cmp_wake[ch] = sync2_reg[`PMW_SRC_CMP1 + ch] & cmp_ready[ch] & cmp_irq_en[ch];
    end
  endgenerate

  // Keyboard interrupt, set up and enabled
  assign kbd_wake = sync2_reg[`PMW_SRC_KBD] & kbd_ready & kbd_irq_en;

  // Watchdog as interrupt only when not in reset role
  assign wdt_irq_wake = sync2_reg[`PMW_SRC_WDT] & ~watchdog_enable_cfg & wdt_irq_en;

  // Brownout as interrupt when selected and enabled
  assign bo_irq_wake = sync2_reg[`PMW_SRC_BO] & ~brownout_disable & brownout_irq_select & bo_irq_en;

  // Converter only while it runs from its own RC clock
  assign adc_wake = sync2_reg[`PMW_SRC_ADC] & adc_rc_clock_select & adc_ready & adc_irq_en;

  // Watchdog overflow resets when the watchdog is enabled
  assign wdt_rst_wake = sync2_reg[`PMW_SRC_WDT] & watchdog_enable_cfg;

  // Brownout resets when detection is on and interrupt not chosen
  assign bo_rst_wake = sync2_reg[`PMW_SRC_BO] & ~brownout_disable & ~brownout_irq_select;

  // External reset input only when enabled
  assign pin_rst_wake = sync2_reg[`PMW_SRC_RST] & ext_reset_enable;

  // Any brownout seen while detection is on
  assign bo_seen = sync2_reg[`PMW_SRC_BO] & ~brownout_disable;

  // Interrupt wakes, all behind the priority check
  assign irq_wake = irq_pri_ok &
                    ((|ext_wake) | kbd_wake | (|cmp_wake) |
                     wdt_irq_wake | bo_irq_wake | adc_wake);

  // Reset-type wakes
  assign rst_wake = wdt_rst_wake | bo_rst_wake | pin_rst_wake;

  // Idle ends on any enabled interrupt or a reset wake
  assign idle_end = (any_irq & irq_pri_ok) | rst_wake;

  // Restart wait length by oscillator type
  assign wait_len = crystal_mode ? `PMW_XTAL_WAIT : `PMW_RC_WAIT;

  // ************************************************
  // Power-down sequencer
  // ************************************************
  // Next state and restart counter
  always @*
  begin
    state_next = state_reg;
    wait_next  = wait_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (power_control_reg[`PMW_BIT_PD])
          state_next = ST_PD;
      end
      ST_PD:
      begin
        if (irq_wake | rst_wake)
        begin
          state_next = ST_WAIT;
          wait_next  = wait_len - 1'b1;
        end
      end
      ST_WAIT:
      begin
        if (wait_reg == {`PMW_WAIT_W{1'b0}})
          state_next = ST_RUN;
        else
          wait_next = wait_reg - 1'b1;
      end
      default:
      begin
        state_next = ST_RUN;
        wait_next  = {`PMW_WAIT_W{1'b0}};
      end
    endcase
  end

  // Sequencer state registers
  always @(posedge clock)
  begin
    if (reset)
    begin
      state_reg <= ST_RUN;
      wait_reg  <= {`PMW_WAIT_W{1'b0}};
    end
    else
    begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
    end
  end

  // ************************************************
  // Power control register
  // ************************************************
  // Address decode shared by write and read
  assign power_control_reg_sel = (addr == `PMW_ADDR_POWER_CONTROL_REG);
  assign power_control_reg_wr  = wr & power_control_reg_sel;

  // Restart count over, power-down ends this edge
  assign pd_done = (state_reg == ST_WAIT) & (state_next == ST_RUN);

  // Idle only counts while power-down is not requested
  assign idle_active = power_control_reg[`PMW_BIT_IDL] & ~power_control_reg[`PMW_BIT_PD];

  // Software writes, flag sets and mode clears
  always @*
  begin
    power_control_next = power_control_reg;
    if (power_control_reg_wr)
    begin
      power_control_next = (wdata & ~`PMW_FLAG_KEEP_MASK)
                         | (wdata & power_control_reg & `PMW_FLAG_KEEP_MASK);
    end
    // Hardware set last so it wins over a clearing write
    if (bo_seen)
      power_control_next[`PMW_BIT_BOF] = 1'b1;
    if (pd_done)
      power_control_next[`PMW_BIT_PD] = 1'b0;
    if (idle_active & idle_end)
      power_control_next[`PMW_BIT_IDL] = 1'b0;
  end

  // Reset value follows the reset cause
  always @(posedge clock)
  begin
    if (reset)
    begin
      if (por_cause)
        power_control_reg <= `PMW_RST_POWERON;
      else if (bor_cause)
        power_control_reg <= `PMW_RST_BROWNOUT;
      else
        power_control_reg <= `PMW_RST_OTHER;
    end
    else
      power_control_reg <= power_control_next;
  end

  // Wake by reset request pulse
  always @(posedge clock)
  begin
    if (reset)
      wake_reset <= 1'b0;
    else
      wake_reset <= (state_reg == ST_PD) & rst_wake;
  end

  // ************************************************
  // Register read and serial bit 7
  // ************************************************
  // Read data one cycle after strobe
  always @(posedge clock)
  begin
    if (reset)
      rdata <= 8'h00;
    else if (rd & power_control_reg_sel)
      rdata <= power_control_reg;
    else
      rdata <= 8'h00;
  end

  // Serial mode bit written only in mode-bit function
  always @(posedge clock)
  begin
    if (reset)
      serial_mode_bit0 <= 1'b0;
    else if (serial_bit7_wr & ~power_control_reg[`PMW_BIT_SER7])
      serial_mode_bit0 <= serial_bit7_wdata;
  end

  assign serial_bit7_read = power_control_reg[`PMW_BIT_SER7] ?
                            framing_error_flag : serial_mode_bit0;

  // ************************************************
  // Mode outputs
  // ************************************************
  // Power-down state and oscillator gating
  assign power_down_mode = (state_reg == ST_PD);
  assign osc_run         = ~power_down_mode;

  // Watchdog, comparators and converter never stop
  assign analog_run      = 1'b1;

  // CPU held from the power-down write until the restart count ends
  assign cpu_hold        = power_down_mode | (state_reg == ST_WAIT) |
                           (state_reg == ST_RUN & power_control_reg[`PMW_BIT_PD]);

  // Idle flag masked by the power-down bit, baud doubling straight from the register
  assign idle_mode       = idle_active;
  assign baud_double     = power_control_reg[`PMW_BIT_BAUD2];
endmodule

// file: test/pmw_top_asserts.sv
// Purpose: Port assertions for pmw_top
// Assumes: One clock, sync reset
// Notes:   Bound from the bench
`timescale 1ns/1ps
module pmw_top_asserts
(
  // Clock, reset, bus
  input wire       clock,
  input wire       reset,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  // Modes
  input wire       osc_run,
  input wire       cpu_hold,
  input wire       idle_mode,
  input wire       power_down_mode,
  input wire       analog_run
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ****************
  // Restart counter
  // ****************
  wire       sel = addr == 8'h87;
  reg [10:0] hold_cnt;
  always @(posedge clock)
    hold_cnt <= (reset || !(cpu_hold && osc_run)) ? 11'h000 : hold_cnt + 11'h001;
  a_osc_stop: assert property (power_down_mode |-> !osc_run)
    else $error("oscillator runs in power-down");
  a_analog_on: assert property (analog_run)
    else $error("analog units stopped");
  a_pd_enter: assert property (wr && sel && wdata[1] && osc_run && !cpu_hold |-> ##2 power_down_mode)
    else $error("power-down not entered");
  a_pd_read: assert property (rd && sel && power_down_mode |=> rdata[1])
    else $error("power-down bit low in power-down");
  a_idle_read: assert property (rd && sel |=> (rdata[0] && !rdata[1]) == $past(idle_mode))
    else $error("idle bit and idle mode differ");
  a_idle_osc: assert property (idle_mode |-> osc_run)
    else $error("oscillator stopped in idle");
  a_wake_hold: assert property ($fell(power_down_mode) |-> cpu_hold && osc_run)
    else $error("no restart wait after wake");
  a_wait_bound: assert property (hold_cnt <= 11'h406)
    else $error("restart wait too long");
  cover property (power_down_mode ##1 !power_down_mode);
  cover property (idle_mode ##1 !idle_mode);
  cover property (rd && sel);
endmodule

// file: test/pmw_top_test.sv
// Purpose: Self-checking bench for pmw_top
// Assumes: 40 MHz clock, sync reset
// Notes:   Model tracks the control byte
`timescale 1ns/1ps
module pmw_top_test;
  reg        clock = 1'b0, reset = 1'b1, por = 1'b1, bor = 1'b0, wr = 1'b0, rd = 1'b0, sm0 = 1'b0;
  reg  [7:0] addr = 8'h00, wdata = 8'h00, m, d, r;
  reg  [5:0] cfg = 6'h00;
  reg [13:0] en = 14'h0000;
  reg  [8:0] ev = 9'h000;
  reg  [2:0] ser = 3'h0;
  reg        w = 1'b0;
  wire [7:0] rdata;
  wire       s7, osc_run, cpu_hold, idle_mode, power_down_mode, bd, sm0_q, wake_rst;
  integer    seed = 32'h2bf2cf5b, miscompares = 0, compares = 0, i, n;
  always #12.5 clock = ~clock;
  pmw_top dut (.clock(clock), .reset(reset), .por_cause(por), .bor_cause(bor), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .watchdog_enable_cfg(cfg[5]), .brownout_disable(cfg[4]),
    .brownout_irq_select(cfg[3]), .adc_rc_clock_select(cfg[2]), .ext_reset_enable(cfg[1]), .crystal_mode(cfg[0]),
    .ext_irq_en(en[13:12]), .kbd_ready(en[11]), .kbd_irq_en(en[10]), .cmp_ready(en[9:8]), .cmp_irq_en(en[7:6]),
    .wdt_irq_en(en[5]), .bo_irq_en(en[4]), .adc_ready(en[3]), .adc_irq_en(en[2]), .irq_pri_ok(en[1]),
    .any_irq(en[0]), .ext_irq_pin(ev[8:7]), .kbd_irq_pin(ev[6]), .cmp_event(ev[5:4]), .wdt_overflow(ev[3]),
    .brownout_event(ev[2]), .ext_reset_pin(ev[1]), .adc_done(ev[0]), .serial_bit7_wr(ser[2]),
    .serial_bit7_wdata(ser[1]), .framing_error_flag(ser[0]), .serial_mode_bit0(sm0_q), .serial_bit7_read(s7),
    .osc_run(osc_run), .cpu_hold(cpu_hold), .idle_mode(idle_mode), .power_down_mode(power_down_mode),
    .analog_run(), .wake_reset(wake_rst), .baud_double(bd));
  // ****************
  // Tasks
  // ****************
  task chk(input [95:0] nm, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e)
      begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task do_reset(input p, input b);
    begin
      @(posedge clock);
      reset <= 1'b1; por <= p; bor <= b;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] v);
    begin
      @(posedge clock);
      addr <= a; wdata <= v; wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(posedge clock);
      addr <= a; rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      d = rdata;
    end
  endtask
  // Enter power-down, prove a disabled source stays asleep, then wake
  task pd_try(input [13:0] e_on, input [8:0] e_ev, input [5:0] c, input rw);
    begin
      @(posedge clock);
      cfg <= (c | 6'h10) & 6'h1D; en <= 14'h0002;
      wr_reg(8'h87, 8'h02);
      ev <= e_ev;
      repeat (300) @(posedge clock);
      rd_reg(8'h87);
      chk("pd set", 8'h02, d & 8'h02);
      chk("pd stay", 8'h01, {7'h0, power_down_mode});
      ev <= 9'h000;
      repeat (3) @(posedge clock);
      en <= e_on; cfg <= c; ev <= e_ev;
      w = 1'b0;
      n = 0;
      while ((power_down_mode !== 1'b0 || cpu_hold !== 1'b0) && n < 1400)
      begin
        @(negedge clock);
        n = n + 1;
        if (wake_rst === 1'b1) w = 1'b1;
      end
      @(posedge clock);
      ev <= 9'h000;
      chk("restart", 8'h01, {7'h0, n >= (c[0] ? 1024 : 256) && n <= (c[0] ? 1032 : 264)});
      chk("wake rst", {7'h0, rw}, {7'h0, w});
      rd_reg(8'h87);
      chk("pd clear", 8'h00, d & 8'h03);
    end
  endtask
  // ****************
  // Tests
  // ****************
  initial
  begin
    for (i = 0; i < 3; i = i + 1)
    begin
      do_reset(i == 2, i == 1);
      rd_reg(8'h87);
      chk("reset val", i == 2 ? 8'h30 : (i == 1 ? 8'h20 : 8'h00), d);
    end
    m = 8'h30;
    $display("reset test done");
    for (i = 0; i < 8; i = i + 1)
    begin
      r = $random(seed);
      wr_reg(8'h87, r & 8'hFC);
      m = {r[7:6], m[5:4] & r[5:4], r[3:2], 2'b00};
      rd_reg({1'b0, r[6:0]});
      chk("unmapped", 8'h00, d);
      rd_reg(8'h87);
      chk("power_control_reg", m, d);
      chk("baud", {7'h0, m[7]}, {7'h0, bd});
      @(posedge clock);
      ser <= {1'b1, r[1:0]};
      @(posedge clock);
      ser[2] <= 1'b0;
      if (!m[6]) sm0 = r[1];
      @(negedge clock);
      chk("bit7", {7'h0, m[6] ? r[0] : sm0}, {7'h0, s7});
      chk("sm0", {7'h0, sm0}, {7'h0, sm0_q});
    end
    @(posedge clock);
    cfg <= 6'h08; ev <= 9'h004;
    repeat (4) @(posedge clock);
    ev <= 9'h000;
    rd_reg(8'h87);
    m = m | 8'h20;
    chk("bo flag", m, d);
    $display("register test done");
    wr_reg(8'h87, m | 8'h01);
    en <= 14'h0001;
    repeat (3) @(negedge clock);
    chk("idle hold", 8'h01, {7'h0, idle_mode});
    en <= 14'h0003;
    repeat (3) @(negedge clock);
    chk("idle end", 8'h00, {7'h0, idle_mode});
    $display("idle test done");
    pd_try(14'h2002, 9'h100, 6'h00, 1'b0);
    pd_try(14'h0C02, 9'h040, 6'h01, 1'b0);
    pd_try(14'h0282, 9'h020, 6'h00, 1'b0);
    pd_try(14'h0022, 9'h008, 6'h01, 1'b0);
    pd_try(14'h0012, 9'h004, 6'h08, 1'b0);
    pd_try(14'h000E, 9'h001, 6'h05, 1'b0);
    pd_try(14'h0002, 9'h008, 6'h20, 1'b1);
    pd_try(14'h0002, 9'h004, 6'h00, 1'b1);
    pd_try(14'h0002, 9'h002, 6'h03, 1'b1);
    $display("power-down test done");
    close_out;
  end
  // Watchdog against a hang
  initial
  begin
    #1000000;
    miscompares = miscompares + 1;
    close_out;
  end
endmodule
bind pmw_top pmw_top_asserts chk_i (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .osc_run(osc_run), .cpu_hold(cpu_hold), .idle_mode(idle_mode),
  .power_down_mode(power_down_mode), .analog_run(analog_run));
